// file: shared/rims_pkg.sv
package rims_pkg;
  localparam int unsigned NUM_SRC = 18;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets (no offsets printed for these registers)
  localparam logic [7:0] OFF_UNMASK_SET = 8'h24;
  localparam logic [7:0] OFF_MASK_SET = 8'h28;
  localparam logic [7:0] OFF_MASK_VIEW = 8'h2c;
  localparam logic [7:0] OFF_RAW_VIEW = 8'h30;
  // field positions
  localparam int unsigned BIT_ALARM_LO = 0;
  localparam int unsigned BIT_FULL_ALARM = 8;
  localparam int unsigned BIT_ROLL_LO = 9;
  localparam int unsigned BIT_TICK = 17;
  localparam logic [NUM_SRC-1:0] SRC_FIELD = 18'h3ffff;
  localparam logic [NUM_SRC-1:0] MASK_RESET = 18'h00000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [31:0] wdata;
  } rims_req_type;
  typedef enum logic [1:0] {
    RIMS_IDLE,
    RIMS_READ,
    RIMS_WRITE
  } rims_op_type;
endpackage

// file: testbench/rims_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rims_top_tb;
  import rims_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, sel;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic err;
  logic [NUM_SRC-1:0] raw_events, expm;
  int mismatches = 0, comparisons = 0, seed = 15461, cyc = 0;
  rims_top rims_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_events(raw_events), .irq(irq));
  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end
  // ceiling well above the ~560 cycles the sequence needs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [NUM_SRC-1:0] exp_mask(input logic s, input logic [NUM_SRC-1:0] m,
    input logic [NUM_SRC-1:0] v);
    return s ? (m | v) : (m & ~v);
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic conclude();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    raw_events = 0;
    expm = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_MASK_VIEW, 32'h0);
    chk("mask_view", 32'h0, rd);
    // walk every bit set, then every bit cleared, then random mixes
    for (int i = 0; i < 60; i++) begin
      w = i < 36 ? 32'h1 << (i % 18) : $random(seed) & {14'h0, SRC_FIELD};
      sel = i < 18 ? 1'b1 : i < 36 ? 1'b0 : 1'($random(seed));
      apb(1'b1, sel ? OFF_UNMASK_SET : OFF_MASK_SET, w);
      chk("write_err", 32'h0, {31'h0, err});
      expm = exp_mask(sel, expm, w[NUM_SRC-1:0]);
      raw_events <= 18'($random(seed));
      apb(1'b0, OFF_MASK_VIEW, 32'h0);
      chk("mask_view", {14'h0, expm}, rd);
      chk("irq", {31'h0, |(raw_events & expm)}, {31'h0, irq});
      apb(1'b0, sel ? OFF_UNMASK_SET : OFF_MASK_SET, 32'h0);
      chk("reserved", 32'h0, rd & 32'hfffc0000);
    end
    apb(1'b1, OFF_MASK_VIEW, 32'h0003ffff);
    chk("view_write_err", 32'h1, {31'h0, err});
    apb(1'b0, OFF_MASK_VIEW, 32'h0);
    chk("view_kept", {14'h0, expm}, rd);
    $display("mask set/clear test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_MASK_VIEW, 32'h0);
    chk("mask_view_reset", 32'h0, rd);
    chk("irq_reset", 32'h0, {31'h0, irq});
    $display("mid-run reset test done");
    conclude();
  end
endmodule
`default_nettype wire

// file: verilog/rims_mask_bank.sv
`timescale 1ns/1ps
`default_nettype none
module rims_mask_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [rims_pkg::NUM_SRC-1:0] set_bits,
  input wire logic [rims_pkg::NUM_SRC-1:0] clr_bits,
  output logic [rims_pkg::NUM_SRC-1:0] mask_state
);
  import rims_pkg::*;
  logic [NUM_SRC-1:0] next_mask_state;
  // only ones act; a zero leaves the bit alone
  assign next_mask_state = (mask_state | set_bits) & ~clr_bits;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_state <= MASK_RESET;
    end else begin
      mask_state <= next_mask_state;
    end
  end
endmodule
`default_nettype wire

// file: verilog/rims_top.sv
`timescale 1ns/1ps
`default_nettype none
module rims_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rims_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [rims_pkg::NUM_SRC-1:0] raw_events,
  output logic irq
);
  import rims_pkg::*;

  rims_req_type req;
  rims_op_type op;
  logic [NUM_SRC-1:0] mask_state;
  logic [NUM_SRC-1:0] set_bits;
  logic [NUM_SRC-1:0] clr_bits;
  logic [NUM_SRC-1:0] wfield;
  logic setup;
  logic unmask_wr;
  logic mask_wr;
  // one write strobe per source, unmask side
  logic tick_irq_unmask;
  logic century_roll_irq_unmask;
  logic year_roll_irq_unmask;
  logic month_roll_irq_unmask;
  logic date_roll_irq_unmask;
  logic week_roll_irq_unmask;
  logic hour_roll_irq_unmask;
  logic minute_roll_irq_unmask;
  logic second_roll_irq_unmask;
  logic full_alarm_irq_unmask;
  logic century_alarm_irq_unmask;
  logic year_alarm_irq_unmask;
  logic month_alarm_irq_unmask;
  logic date_alarm_irq_unmask;
  logic week_alarm_irq_unmask;
  logic hour_alarm_irq_unmask;
  logic minute_alarm_irq_unmask;
  logic second_alarm_irq_unmask;
  // one write strobe per source, mask side
  logic tick_irq_mask;
  logic century_roll_irq_mask;
  logic year_roll_irq_mask;
  logic month_roll_irq_mask;
  logic date_roll_irq_mask;
  logic week_roll_irq_mask;
  logic hour_roll_irq_mask;
  logic minute_roll_irq_mask;
  logic second_roll_irq_mask;
  logic full_alarm_irq_mask;
  logic century_alarm_irq_mask;
  logic year_alarm_irq_mask;
  logic month_alarm_irq_mask;
  logic date_alarm_irq_mask;
  logic week_alarm_irq_mask;
  logic hour_alarm_irq_mask;
  logic minute_alarm_irq_mask;
  logic second_alarm_irq_mask;
  logic hit_unmask;
  logic hit_mask;
  logic hit_view;
  logic hit_raw;
  logic mapped;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_irq;

  function automatic logic [31:0] pad_field(input logic [NUM_SRC-1:0] f);
    pad_field = {{(32 - NUM_SRC){1'b0}}, f};
  endfunction

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign op = !(psel && penable) ? RIMS_IDLE : (req.write ? RIMS_WRITE : RIMS_READ);
  assign setup = psel && !penable;
  assign hit_unmask = (req.addr == OFF_UNMASK_SET);
  assign hit_mask = (req.addr == OFF_MASK_SET);
  assign hit_view = (req.addr == OFF_MASK_VIEW);
  assign hit_raw = (req.addr == OFF_RAW_VIEW);
  assign mapped = hit_unmask | hit_mask | hit_view | hit_raw;

  // bits 31..18 of the written word are dropped; the low byte lanes gate the field
  assign wfield = req.wdata[NUM_SRC-1:0] & {{2{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}} & SRC_FIELD;
  assign unmask_wr = (op == RIMS_WRITE) && hit_unmask;
  assign mask_wr = (op == RIMS_WRITE) && hit_mask;

  // a written zero gives no strobe, so the mask bit keeps its value
  assign tick_irq_unmask = unmask_wr && wfield[BIT_TICK];
  assign century_roll_irq_unmask = unmask_wr && wfield[BIT_ROLL_LO + 7];
  assign year_roll_irq_unmask = unmask_wr && wfield[BIT_ROLL_LO + 6];
  assign month_roll_irq_unmask = unmask_wr && wfield[BIT_ROLL_LO + 5];
  assign date_roll_irq_unmask = unmask_wr && wfield[BIT_ROLL_LO + 4];
  assign week_roll_irq_unmask = unmask_wr && wfield[BIT_ROLL_LO + 3];
  assign hour_roll_irq_unmask = unmask_wr && wfield[BIT_ROLL_LO + 2];
  assign minute_roll_irq_unmask = unmask_wr && wfield[BIT_ROLL_LO + 1];
  assign second_roll_irq_unmask = unmask_wr && wfield[BIT_ROLL_LO];
  assign full_alarm_irq_unmask = unmask_wr && wfield[BIT_FULL_ALARM];
  assign century_alarm_irq_unmask = unmask_wr && wfield[BIT_ALARM_LO + 7];
  assign year_alarm_irq_unmask = unmask_wr && wfield[BIT_ALARM_LO + 6];
  assign month_alarm_irq_unmask = unmask_wr && wfield[BIT_ALARM_LO + 5];
  assign date_alarm_irq_unmask = unmask_wr && wfield[BIT_ALARM_LO + 4];
  assign week_alarm_irq_unmask = unmask_wr && wfield[BIT_ALARM_LO + 3];
  assign hour_alarm_irq_unmask = unmask_wr && wfield[BIT_ALARM_LO + 2];
  assign minute_alarm_irq_unmask = unmask_wr && wfield[BIT_ALARM_LO + 1];
  assign second_alarm_irq_unmask = unmask_wr && wfield[BIT_ALARM_LO];

  assign tick_irq_mask = mask_wr && wfield[BIT_TICK];
  assign century_roll_irq_mask = mask_wr && wfield[BIT_ROLL_LO + 7];
  assign year_roll_irq_mask = mask_wr && wfield[BIT_ROLL_LO + 6];
  assign month_roll_irq_mask = mask_wr && wfield[BIT_ROLL_LO + 5];
  assign date_roll_irq_mask = mask_wr && wfield[BIT_ROLL_LO + 4];
  assign week_roll_irq_mask = mask_wr && wfield[BIT_ROLL_LO + 3];
  assign hour_roll_irq_mask = mask_wr && wfield[BIT_ROLL_LO + 2];
  assign minute_roll_irq_mask = mask_wr && wfield[BIT_ROLL_LO + 1];
  assign second_roll_irq_mask = mask_wr && wfield[BIT_ROLL_LO];
  assign full_alarm_irq_mask = mask_wr && wfield[BIT_FULL_ALARM];
  assign century_alarm_irq_mask = mask_wr && wfield[BIT_ALARM_LO + 7];
  assign year_alarm_irq_mask = mask_wr && wfield[BIT_ALARM_LO + 6];
  assign month_alarm_irq_mask = mask_wr && wfield[BIT_ALARM_LO + 5];
  assign date_alarm_irq_mask = mask_wr && wfield[BIT_ALARM_LO + 4];
  assign week_alarm_irq_mask = mask_wr && wfield[BIT_ALARM_LO + 3];
  assign hour_alarm_irq_mask = mask_wr && wfield[BIT_ALARM_LO + 2];
  assign minute_alarm_irq_mask = mask_wr && wfield[BIT_ALARM_LO + 1];
  assign second_alarm_irq_mask = mask_wr && wfield[BIT_ALARM_LO];

  assign set_bits = {
    tick_irq_unmask,
    century_roll_irq_unmask,
    year_roll_irq_unmask,
    month_roll_irq_unmask,
    date_roll_irq_unmask,
    week_roll_irq_unmask,
    hour_roll_irq_unmask,
    minute_roll_irq_unmask,
    second_roll_irq_unmask,
    full_alarm_irq_unmask,
    century_alarm_irq_unmask,
    year_alarm_irq_unmask,
    month_alarm_irq_unmask,
    date_alarm_irq_unmask,
    week_alarm_irq_unmask,
    hour_alarm_irq_unmask,
    minute_alarm_irq_unmask,
    second_alarm_irq_unmask
  };
  assign clr_bits = {
    tick_irq_mask,
    century_roll_irq_mask,
    year_roll_irq_mask,
    month_roll_irq_mask,
    date_roll_irq_mask,
    week_roll_irq_mask,
    hour_roll_irq_mask,
    minute_roll_irq_mask,
    second_roll_irq_mask,
    full_alarm_irq_mask,
    century_alarm_irq_mask,
    year_alarm_irq_mask,
    month_alarm_irq_mask,
    date_alarm_irq_mask,
    week_alarm_irq_mask,
    hour_alarm_irq_mask,
    minute_alarm_irq_mask,
    second_alarm_irq_mask
  };

  // write-only set/clear registers read as zero; reserved bits read zero
  // read data is loaded in the setup cycle so that it stands through the access cycle
  assign next_prdata = !(setup && !req.write) ? ZERO_WORD :
                       hit_view ? pad_field(mask_state) :
                       hit_raw ? pad_field(raw_events) : ZERO_WORD;
  // writes to the read-only views are errors too
  assign next_pslverr = setup && (!mapped || (req.write && (hit_view || hit_raw)));
  assign next_irq = |(raw_events & mask_state);

  rims_mask_bank u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .set_bits(set_bits),
    .clr_bits(clr_bits),
    .mask_state(mask_state)
  );

  // zero-wait slave: prdata, pslverr and pready are registered at the end of the setup cycle, the access cycle
  // is answered with pready high from the flop loaded in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= ZERO_WORD;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  sequence unmask_write_s;
    unmask_wr;
  endsequence

  sequence mask_write_s;
    mask_wr;
  endsequence

  sequence view_read_s;
    setup && !req.write && hit_view;
  endsequence

  roll_unmask_a: assert property (@(posedge pclk) disable iff (!presetn)
    unmask_write_s |=> (mask_state[BIT_TICK-1:BIT_ROLL_LO] & $past(wfield[BIT_TICK-1:BIT_ROLL_LO]))
      == $past(wfield[BIT_TICK-1:BIT_ROLL_LO]))
    else $error("rollover unmask bits did not set");

  alarm_unmask_a: assert property (@(posedge pclk) disable iff (!presetn)
    unmask_write_s |=> (mask_state[BIT_FULL_ALARM-1:BIT_ALARM_LO] & $past(wfield[BIT_FULL_ALARM-1:BIT_ALARM_LO]))
      == $past(wfield[BIT_FULL_ALARM-1:BIT_ALARM_LO]))
    else $error("alarm unmask bits did not set");

  full_unmask_a: assert property (@(posedge pclk) disable iff (!presetn)
    unmask_write_s ##0 wfield[BIT_FULL_ALARM] |=> mask_state[BIT_FULL_ALARM])
    else $error("full alarm unmask did not set");

  tick_unmask_a: assert property (@(posedge pclk) disable iff (!presetn)
    unmask_write_s ##0 wfield[BIT_TICK] |=> mask_state[BIT_TICK])
    else $error("tick unmask did not set");

  roll_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask_write_s |=> (mask_state[BIT_TICK-1:BIT_ROLL_LO] & $past(wfield[BIT_TICK-1:BIT_ROLL_LO])) == '0)
    else $error("rollover mask bits did not clear");

  alarm_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask_write_s |=> (mask_state[BIT_FULL_ALARM-1:BIT_ALARM_LO] & $past(wfield[BIT_FULL_ALARM-1:BIT_ALARM_LO])) == '0)
    else $error("alarm mask bits did not clear");

  full_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask_write_s ##0 wfield[BIT_FULL_ALARM] |=> !mask_state[BIT_FULL_ALARM])
    else $error("full alarm mask did not clear");

  tick_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    mask_write_s ##0 wfield[BIT_TICK] |=> !mask_state[BIT_TICK])
    else $error("tick mask did not clear");

  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:NUM_SRC] == '0)
    else $error("reserved read bits not zero");

  view_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    view_read_s |=> prdata == pad_field($past(mask_state)))
    else $error("mask view read wrong");

  zero_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    (unmask_wr || mask_wr) |=> ((mask_state ^ $past(mask_state)) & ~$past(wfield)) == '0)
    else $error("zero-written mask bit changed");

  idle_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(unmask_wr || mask_wr) |=> $stable(mask_state))
    else $error("mask changed without a write");

  irq_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == $past(|(raw_events & mask_state)))
    else $error("irq does not follow raw and mask");

endmodule
`default_nettype wire
